// ### rtl/sapm_consts.vh
// Constants for the status, alert and power monitor command block
`ifndef SAPM_CONSTS_VH
`define SAPM_CONSTS_VH
// Register offsets (word index on the plain register port)
`define SAPM_REG_CLEAR_FAULTS   8'h03
`define SAPM_REG_OPERATION      8'h01
`define SAPM_REG_STATUS         8'h10
`define SAPM_REG_DEVICE_CFG     8'h11
`define SAPM_REG_PIN_ONE_SETUP  8'h12
`define SAPM_REG_PIN_TWO_SETUP  8'h13
`define SAPM_REG_MON_SETUP      8'h14
`define SAPM_REG_MON_START      8'h15
`define SAPM_REG_READ_IOUT      8'h20
`define SAPM_REG_READ_VIN       8'h21
`define SAPM_REG_READ_VOUT      8'h22
`define SAPM_REG_MAX_IOUT       8'h23
`define SAPM_REG_MAX_VIN        8'h24
`define SAPM_REG_MAX_VOUT       8'h25
`define SAPM_REG_VIN_OV_LIM     8'h30
`define SAPM_REG_VIN_UV_LIM     8'h31
`define SAPM_REG_VOUT_OV_LIM    8'h32
`define SAPM_REG_VOUT_UV_LIM    8'h33
`define SAPM_REG_IOUT_OC_LIM    8'h34
`define SAPM_REG_IOUT_LIM2      8'h35
// Status bit positions
`define SAPM_ST_UV_FAULT        0
`define SAPM_ST_OV_FAULT        1
`define SAPM_ST_OC_FAULT        2
`define SAPM_ST_TIMER_ACT       3
`define SAPM_ST_IOUT_OC_WARN    4
`define SAPM_ST_IOUT_WARN2      5
`define SAPM_ST_VIN_UV_WARN     6
`define SAPM_ST_VIN_OV_WARN     7
`define SAPM_ST_VOUT_UV_WARN    8
`define SAPM_ST_VOUT_OV_WARN    9
`define SAPM_ST_CML             10
`define SAPM_ST_WIDTH           11
// Pin setup fields: [10:0] mask, [12:11] mode, [13] gpo level, [14] invert
`define SAPM_PIN_MODE_LSB       11
`define SAPM_PIN_GPO_BIT        13
`define SAPM_PIN_INV_BIT        14
`define SAPM_MODE_ALERT         2'h0
`define SAPM_MODE_GPO           2'h1
`define SAPM_MODE_TRIGGER       2'h2
// Monitor setup fields
`define SAPM_MON_CONT_BIT       0
`define SAPM_MON_VOUT_BIT       1
`define SAPM_MON_RANGE_BIT      2
`define SAPM_MON_IAVG_LSB       3
`define SAPM_MON_VAVG_LSB       6
// Device config fields
`define SAPM_CFG_OP_EN_BIT      0
`define SAPM_CFG_W2_UNDER_BIT   1
// Reset values
`define SAPM_LIM_MIN            12'h000
`define SAPM_LIM_MAX            12'hfff
`define SAPM_PIN_ONE_RESET      16'h0000
`define SAPM_PIN_TWO_RESET      16'h0008
`define SAPM_MON_SETUP_RESET    16'h0000
`endif

// ### rtl/sapm_monitor.v
// Status latching, alert pins, power monitor control, peaks and warning limits
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sapm_consts.vh"

module sapm_monitor #(
    parameter integer AVG_MAX = 128
) (
    input  wire        clock,
    input  wire        reset_n,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    input  wire        uv_fault_cond,
    input  wire        ov_fault_cond,
    input  wire        oc_fault_cond,
    input  wire        timer_active_cond,
    input  wire        comm_error_cond,
    input  wire        adc_done,
    input  wire [11:0] adc_current,
    input  wire [11:0] adc_voltage,
    output reg         adc_start,
    output reg         adc_sel_vout,
    output reg         adc_high_range,
    input  wire        multipurpose_pin_one_in,
    output reg         multipurpose_pin_one_oe_n,
    output reg         multipurpose_pin_one_out,
    output reg         multipurpose_pin_two_oe_n,
    output reg         multipurpose_pin_two_out,
    output reg         output_on,
    output reg         monitor_busy
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [7:0] avg_count;
    input [2:0] code;
    begin
        avg_count = 8'h01 << code;
    end
endfunction

function [15:0] sext;
    input [11:0] v;
    begin
        sext = {4'h0, v};
    end
endfunction

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [`SAPM_ST_WIDTH-1:0] status;
reg [15:0] pin_one_setup;
reg [15:0] pin_two_setup;
reg [15:0] mon_setup;
reg [1:0]  dev_cfg;
reg [11:0] read_iout, read_vin, read_vout;
reg [11:0] max_iout, max_vin, max_vout;
reg [11:0] vin_ov_lim, vin_uv_lim, vout_ov_lim, vout_uv_lim, iout_oc_lim, iout_lim2;
reg        trig_s1, trig_s2, trig_d;
reg        cont_run;
reg        wait_done;
reg [7:0]  avg_left;
reg [19:0] acc_i, acc_v;
reg        new_sample;
reg        alert_one, alert_two;
reg [`SAPM_ST_WIDTH-1:0] status_prev;

wire wr_clear  = reg_write && reg_addr == `SAPM_REG_CLEAR_FAULTS;
wire wr_op     = reg_write && reg_addr == `SAPM_REG_OPERATION && dev_cfg[`SAPM_CFG_OP_EN_BIT];
wire op_clear  = wr_op && !output_on && reg_wdata[0];
wire clear_all = wr_clear || op_clear;
wire [1:0] mode_one = pin_one_setup[`SAPM_PIN_MODE_LSB+1:`SAPM_PIN_MODE_LSB];
wire [1:0] mode_two = pin_two_setup[`SAPM_PIN_MODE_LSB+1:`SAPM_PIN_MODE_LSB];
wire [2:0] iavg = mon_setup[`SAPM_MON_IAVG_LSB+2:`SAPM_MON_IAVG_LSB];
wire [2:0] vavg = mon_setup[`SAPM_MON_VAVG_LSB+2:`SAPM_MON_VAVG_LSB];
wire [2:0] avg_code = (iavg > vavg) ? iavg : vavg;
wire [7:0] n_avg = avg_count(avg_code);
wire [19:0] next_acc_i = acc_i + {8'h00, adc_current};
wire [19:0] next_acc_v = acc_v + {8'h00, adc_voltage};
wire [19:0] shr_i = next_acc_i >> avg_code;
wire [19:0] shr_v = next_acc_v >> avg_code;
wire [11:0] avg_i = shr_i[11:0];
wire [11:0] avg_v = shr_v[11:0];
wire trig_rise = mode_one == `SAPM_MODE_TRIGGER && trig_s2 && !trig_d;
wire wr_start  = reg_write && reg_addr == `SAPM_REG_MON_START;
wire start_req = (wr_start && reg_wdata[0]) || trig_rise;
wire stop_req  = wr_start && !reg_wdata[0];

// ----------------------------------------------------------------
// Warning compares on the fresh averaged sample
// ----------------------------------------------------------------
reg [`SAPM_ST_WIDTH-1:0] cond;
always @* begin
    cond = {`SAPM_ST_WIDTH{1'b0}};
    cond[`SAPM_ST_UV_FAULT]  = uv_fault_cond;
    cond[`SAPM_ST_OV_FAULT]  = ov_fault_cond;
    cond[`SAPM_ST_OC_FAULT]  = oc_fault_cond;
    cond[`SAPM_ST_TIMER_ACT] = timer_active_cond;
    cond[`SAPM_ST_CML]       = comm_error_cond;
    if (new_sample) begin
        cond[`SAPM_ST_IOUT_OC_WARN] = read_iout > iout_oc_lim;
        cond[`SAPM_ST_IOUT_WARN2] = dev_cfg[`SAPM_CFG_W2_UNDER_BIT] ? (read_iout < iout_lim2)
                                                                    : (read_iout > iout_lim2);
        if (!adc_sel_vout) begin
            cond[`SAPM_ST_VIN_UV_WARN] = read_vin < vin_uv_lim;
            cond[`SAPM_ST_VIN_OV_WARN] = read_vin > vin_ov_lim;
        end else begin
            cond[`SAPM_ST_VOUT_UV_WARN] = read_vout < vout_uv_lim;
            cond[`SAPM_ST_VOUT_OV_WARN] = read_vout > vout_ov_lim;
        end
    end
end

// ----------------------------------------------------------------
// Status, setup and limit registers
// ----------------------------------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        status        <= {`SAPM_ST_WIDTH{1'b0}};
        status_prev   <= {`SAPM_ST_WIDTH{1'b0}};
        pin_one_setup <= `SAPM_PIN_ONE_RESET;
        pin_two_setup <= `SAPM_PIN_TWO_RESET;
        mon_setup     <= `SAPM_MON_SETUP_RESET;
        dev_cfg       <= 2'h0;
        output_on     <= 1'b1;
        vin_ov_lim    <= `SAPM_LIM_MAX;
        vin_uv_lim    <= `SAPM_LIM_MIN;
        vout_ov_lim   <= `SAPM_LIM_MAX;
        vout_uv_lim   <= `SAPM_LIM_MIN;
        iout_oc_lim   <= `SAPM_LIM_MAX;
        iout_lim2     <= `SAPM_LIM_MAX;
    end else begin
        status      <= (clear_all ? {`SAPM_ST_WIDTH{1'b0}} : status) | cond;
        status_prev <= status;
        if (wr_op)
            output_on <= reg_wdata[0];
        if (reg_write) begin
            case (reg_addr)
                `SAPM_REG_DEVICE_CFG:    dev_cfg       <= reg_wdata[1:0];
                `SAPM_REG_PIN_ONE_SETUP: pin_one_setup <= reg_wdata;
                `SAPM_REG_PIN_TWO_SETUP: pin_two_setup <= reg_wdata;
                `SAPM_REG_MON_SETUP:     mon_setup     <= reg_wdata;
                `SAPM_REG_VIN_OV_LIM:    vin_ov_lim    <= reg_wdata[11:0];
                `SAPM_REG_VIN_UV_LIM:    vin_uv_lim    <= reg_wdata[11:0];
                `SAPM_REG_VOUT_OV_LIM:   vout_ov_lim   <= reg_wdata[11:0];
                `SAPM_REG_VOUT_UV_LIM:   vout_uv_lim   <= reg_wdata[11:0];
                `SAPM_REG_IOUT_OC_LIM:   iout_oc_lim   <= reg_wdata[11:0];
                `SAPM_REG_IOUT_LIM2:     iout_lim2     <= reg_wdata[11:0];
                default: ;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Monitor sequencer and peaks
// ----------------------------------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        trig_s1        <= 1'b0;
        trig_s2        <= 1'b0;
        trig_d         <= 1'b0;
        monitor_busy   <= 1'b0;
        cont_run       <= 1'b0;
        wait_done      <= 1'b0;
        adc_start      <= 1'b0;
        adc_sel_vout   <= 1'b0;
        adc_high_range <= 1'b0;
        avg_left       <= 8'h00;
        acc_i          <= 20'h00000;
        acc_v          <= 20'h00000;
        new_sample     <= 1'b0;
        read_iout      <= 12'h000;
        read_vin       <= 12'h000;
        read_vout      <= 12'h000;
        max_iout       <= 12'h000;
        max_vin        <= 12'h000;
        max_vout       <= 12'h000;
    end else begin
        trig_s1    <= multipurpose_pin_one_in;
        trig_s2    <= trig_s1;
        trig_d     <= trig_s2;
        adc_start  <= 1'b0;
        new_sample <= 1'b0;
        if (stop_req) begin
            monitor_busy <= 1'b0;
            cont_run     <= 1'b0;
            wait_done    <= 1'b0;
        end else if (start_req && !monitor_busy) begin
            monitor_busy   <= 1'b1;
            cont_run       <= mon_setup[`SAPM_MON_CONT_BIT] && !trig_rise;
            adc_sel_vout   <= mon_setup[`SAPM_MON_VOUT_BIT];
            adc_high_range <= mon_setup[`SAPM_MON_RANGE_BIT];
            avg_left       <= n_avg;
            acc_i          <= 20'h00000;
            acc_v          <= 20'h00000;
            adc_start      <= 1'b1;
            wait_done      <= 1'b1;
        end else if (wait_done && adc_done) begin
            if (avg_left == 8'h01) begin
                read_iout  <= avg_i;
                if (adc_sel_vout)
                    read_vout <= avg_v;
                else
                    read_vin  <= avg_v;
                if (avg_i > max_iout)
                    max_iout <= avg_i;
                if (!adc_sel_vout && avg_v > max_vin)
                    max_vin <= avg_v;
                if (adc_sel_vout && avg_v > max_vout)
                    max_vout <= avg_v;
                new_sample <= 1'b1;
                acc_i      <= 20'h00000;
                acc_v      <= 20'h00000;
                avg_left   <= n_avg;
                if (cont_run) begin
                    adc_start <= 1'b1;
                end else begin
                    monitor_busy <= 1'b0;
                    wait_done    <= 1'b0;
                end
            end else begin
                acc_i     <= next_acc_i;
                acc_v     <= next_acc_v;
                avg_left  <= avg_left - 8'h01;
                adc_start <= 1'b1;
            end
        end
        if (reg_write && reg_wdata == 16'h0000) begin
            case (reg_addr)
                `SAPM_REG_MAX_IOUT: max_iout <= 12'h000;
                `SAPM_REG_MAX_VIN:  max_vin  <= 12'h000;
                `SAPM_REG_MAX_VOUT: max_vout <= 12'h000;
                default: ;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Alert and general output pins
// ----------------------------------------------------------------
wire rising_one = |(status & ~status_prev & pin_one_setup[`SAPM_ST_WIDTH-1:0]);
wire rising_two = |(status & ~status_prev & pin_two_setup[`SAPM_ST_WIDTH-1:0]);
wire level_one  = mode_one == `SAPM_MODE_GPO ? pin_one_setup[`SAPM_PIN_GPO_BIT]
                                             : alert_one ^ ~pin_one_setup[`SAPM_PIN_INV_BIT];
wire level_two  = mode_two == `SAPM_MODE_GPO ? pin_two_setup[`SAPM_PIN_GPO_BIT]
                                             : alert_two ^ ~pin_two_setup[`SAPM_PIN_INV_BIT];

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        alert_one                 <= 1'b0;
        alert_two                 <= 1'b0;
        multipurpose_pin_one_oe_n <= 1'b1;
        multipurpose_pin_one_out  <= 1'b0;
        multipurpose_pin_two_oe_n <= 1'b1;
        multipurpose_pin_two_out  <= 1'b0;
    end else begin
        // mask used only in alert mode; a fresh rise beats a clear
        if (mode_one == `SAPM_MODE_ALERT && rising_one)
            alert_one <= 1'b1;
        else if (clear_all)
            alert_one <= 1'b0;
        if (mode_two == `SAPM_MODE_ALERT && rising_two)
            alert_two <= 1'b1;
        else if (clear_all)
            alert_two <= 1'b0;
        // Open drain: drive only a low level
        multipurpose_pin_one_out  <= 1'b0;
        multipurpose_pin_two_out  <= 1'b0;
        multipurpose_pin_one_oe_n <= (mode_one == `SAPM_MODE_TRIGGER) ? 1'b1 : level_one;
        multipurpose_pin_two_oe_n <= level_two;
    end
end

// ----------------------------------------------------------------
// Read port
// ----------------------------------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        reg_rdata <= 16'h0000;
    end else if (reg_read) begin
        case (reg_addr)
            `SAPM_REG_OPERATION:     reg_rdata <= {15'h0000, output_on};
            `SAPM_REG_STATUS:        reg_rdata <= {5'h00, status};
            `SAPM_REG_DEVICE_CFG:    reg_rdata <= {14'h0000, dev_cfg};
            `SAPM_REG_PIN_ONE_SETUP: reg_rdata <= pin_one_setup;
            `SAPM_REG_PIN_TWO_SETUP: reg_rdata <= pin_two_setup;
            `SAPM_REG_MON_SETUP:     reg_rdata <= mon_setup;
            `SAPM_REG_MON_START:     reg_rdata <= {15'h0000, monitor_busy};
            `SAPM_REG_READ_IOUT:     reg_rdata <= sext(read_iout);
            `SAPM_REG_READ_VIN:      reg_rdata <= sext(read_vin);
            `SAPM_REG_READ_VOUT:     reg_rdata <= sext(read_vout);
            `SAPM_REG_MAX_IOUT:      reg_rdata <= sext(max_iout);
            `SAPM_REG_MAX_VIN:       reg_rdata <= sext(max_vin);
            `SAPM_REG_MAX_VOUT:      reg_rdata <= sext(max_vout);
            `SAPM_REG_VIN_OV_LIM:    reg_rdata <= sext(vin_ov_lim);
            `SAPM_REG_VIN_UV_LIM:    reg_rdata <= sext(vin_uv_lim);
            `SAPM_REG_VOUT_OV_LIM:   reg_rdata <= sext(vout_ov_lim);
            `SAPM_REG_VOUT_UV_LIM:   reg_rdata <= sext(vout_uv_lim);
            `SAPM_REG_IOUT_OC_LIM:   reg_rdata <= sext(iout_oc_lim);
            `SAPM_REG_IOUT_LIM2:     reg_rdata <= sext(iout_lim2);
            default:                 reg_rdata <= 16'h0000;
        endcase
    end else begin
        reg_rdata <= 16'h0000;
    end
end

endmodule // sapm_monitor
`default_nettype wire

// ### verification/sapm_adc_model.sv
// Converter model answering sample requests with bench-set codes
`timescale 1ns/1ps
`default_nettype none
module sapm_adc_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        adc_start,
    input  wire logic [11:0] cur_code,
    input  wire logic [11:0] volt_code,
    input  wire logic [7:0]  latency,
    output var  logic        adc_done,
    output var  logic [11:0] adc_current,
    output var  logic [11:0] adc_voltage
);
    logic [7:0] cnt;
    logic       run;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
            run <= 1'b0;
            adc_done <= 1'b0;
            adc_current <= 12'h000;
            adc_voltage <= 12'h000;
        end else begin
            adc_done <= 1'b0;
            // Codes churn outside the done cycle
            adc_current <= ~adc_current;
            adc_voltage <= ~adc_voltage;
            if (adc_start) begin
                run <= 1'b1;
                cnt <= latency;
            end else if (run && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (run) begin
                run <= 1'b0;
                adc_done <= 1'b1;
                adc_current <= cur_code;
                adc_voltage <= volt_code;
            end
        end
    end
endmodule // sapm_adc_model
`default_nettype wire

// ### verification/sapm_chk_monitor.sv
// Port checker for the status, alert and monitor command block
`timescale 1ns/1ps
`default_nettype none
`include "sapm_consts.vh"
module sapm_chk #(
    parameter integer AVG_MAX = 128
) (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        adc_start,
    input wire logic        adc_sel_vout,
    input wire logic        adc_high_range,
    input wire logic        monitor_busy,
    input wire logic        multipurpose_pin_one_in,
    input wire logic        multipurpose_pin_one_oe_n,
    input wire logic        multipurpose_pin_two_oe_n
);
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;
    logic [15:0] cfg_mon;
    // ---------------------------
    // Shadow of the setup words
    // ---------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfg_one <= `SAPM_PIN_ONE_RESET;
            cfg_two <= `SAPM_PIN_TWO_RESET;
            cfg_mon <= `SAPM_MON_SETUP_RESET;
        end else if (reg_write) begin
            if (reg_addr == `SAPM_REG_PIN_ONE_SETUP)
                cfg_one <= reg_wdata;
            if (reg_addr == `SAPM_REG_PIN_TWO_SETUP)
                cfg_two <= reg_wdata;
            if (reg_addr == `SAPM_REG_MON_SETUP)
                cfg_mon <= reg_wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    read_idle_a:
        assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data outside answer");
    start_cmd_a:
        assert property (reg_write && reg_addr == `SAPM_REG_MON_START && reg_wdata[0] && !monitor_busy
            |=> adc_start) else $error("start command gave no request");
    start_pulse_a:
        assert property (adc_start |=> !adc_start) else $error("request longer than one cycle");
    range_sel_a:
        assert property (adc_start |-> adc_sel_vout == cfg_mon[`SAPM_MON_VOUT_BIT]
            && adc_high_range == cfg_mon[`SAPM_MON_RANGE_BIT]) else $error("source or range wrong");
    gpo_one_a:
        assert property (cfg_one[12:11] == `SAPM_MODE_GPO && !cfg_one[`SAPM_PIN_INV_BIT] && $stable(cfg_one)
            |-> multipurpose_pin_one_oe_n == cfg_one[`SAPM_PIN_GPO_BIT]) else $error("pin one level wrong");
    gpo_two_a:
        assert property (cfg_two[12:11] == `SAPM_MODE_GPO && !cfg_two[`SAPM_PIN_INV_BIT] && $stable(cfg_two)
            |-> multipurpose_pin_two_oe_n == cfg_two[`SAPM_PIN_GPO_BIT]) else $error("pin two level wrong");
    trig_idle_a:
        assert property (cfg_one[12:11] == `SAPM_MODE_TRIGGER && $stable(cfg_one)
            |-> multipurpose_pin_one_oe_n) else $error("trigger pin driven");
    trig_start_a:
        assert property ($rose(multipurpose_pin_one_in) && cfg_one[12:11] == `SAPM_MODE_TRIGGER && !monitor_busy
            ##1 multipurpose_pin_one_in [*3] |-> ##[0:3] adc_start) else $error("trigger gave no request");
endmodule // sapm_chk
bind sapm_monitor sapm_chk #(.AVG_MAX(AVG_MAX)) i_sapm_chk (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_sel_vout(adc_sel_vout), .adc_high_range(adc_high_range), .monitor_busy(monitor_busy),
    .multipurpose_pin_one_in(multipurpose_pin_one_in),
    .multipurpose_pin_one_oe_n(multipurpose_pin_one_oe_n),
    .multipurpose_pin_two_oe_n(multipurpose_pin_two_oe_n));
`default_nettype wire

// ### verification/test_status_alert_power_monitor_cmds.sv
// Self-checking bench for the status, alert and monitor command block
`timescale 1ns/1ps
`default_nettype none
`include "sapm_consts.vh"
module test_status_alert_power_monitor_cmds;
    logic        clock, reset_n, wr_s, rd_s, done, start, sel_vout, hi_rng, pin_in;
    logic        one_oe_n, two_oe_n, output_on, busy, one_out, two_out;
    logic [7:0]  addr, latency;
    logic [15:0] wdata, rdata;
    logic [4:0]  cond;
    logic [11:0] a_cur, a_volt, cur_code, volt_code;
    logic [31:0] lfsr;
    integer      error_cnt, tests_run, i, j, n, ci, cv, sel, pol, want, peak_i;
    integer      peak_v[2];
    integer      lim[6];
    sapm_monitor i_sapm_monitor (
        .clock(clock), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .reg_rdata(rdata), .uv_fault_cond(cond[0]), .ov_fault_cond(cond[1]),
        .oc_fault_cond(cond[2]), .timer_active_cond(cond[3]), .comm_error_cond(cond[4]),
        .adc_done(done), .adc_current(a_cur), .adc_voltage(a_volt), .adc_start(start),
        .adc_sel_vout(sel_vout), .adc_high_range(hi_rng), .multipurpose_pin_one_in(pin_in),
        .multipurpose_pin_one_oe_n(one_oe_n), .multipurpose_pin_one_out(one_out),
        .multipurpose_pin_two_oe_n(two_oe_n), .multipurpose_pin_two_out(two_out), .output_on(output_on),
        .monitor_busy(busy));
    sapm_adc_model i_sapm_adc_model (
        .clock(clock), .reset_n(reset_n), .adc_start(start), .cur_code(cur_code), .volt_code(volt_code),
        .latency(latency), .adc_done(done), .adc_current(a_cur), .adc_voltage(a_volt));
    // ---------------------------
    // Bus cycles and comparisons
    // ---------------------------
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        #1 check(name, rdata, exp);
        @(posedge clock);
    endtask
    task automatic pins(input logic one, input logic two);
        @(negedge clock);
        check("pin one", {14'h0, one_out, one_oe_n}, {15'h0, one});
        check("pin two", {14'h0, two_out, two_oe_n}, {15'h0, two});
        @(posedge clock);
    endtask
    task automatic pulse(input logic [4:0] c, input logic [4:0] after);
        cond <= c;
        @(posedge clock);
        cond <= after;
        repeat (3) @(posedge clock);
    endtask
    task automatic idle;
        repeat (3) @(posedge clock);
        for (n = 0; n < 3000 && busy; n = n + 1)
            @(posedge clock);
        check("monitor idle", {15'h0, busy}, 16'h0000);
        repeat (4) @(posedge clock);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial clock = 1'b0;
    always #5 clock = ~clock;
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        $display("Error watchdog expected end seen hang");
        finish_test();
    end
    initial begin
        {error_cnt, tests_run, peak_i, peak_v[0], peak_v[1]} = '0;
        {reset_n, wr_s, rd_s, pin_in, addr, wdata, cond, cur_code, volt_code} = '0;
        lfsr = 32'h9f86;
        latency = 8'h02;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 6; i = i + 1)
            rd("limit default", 8'h30 + i[7:0], (i == 1 || i == 3) ? 16'h0000 : 16'h0fff);
        wr(8'h7f, 16'hffff);
        rd("unmapped", 8'h7f, 16'h0000);
        $display("Test defaults done");
        wr(`SAPM_REG_PIN_ONE_SETUP, 16'h0001);
        wr(`SAPM_REG_PIN_TWO_SETUP, 16'h0004);
        pulse(5'h01, 5'h00);
        pins(1'b0, 1'b1);
        rd("uv latched", `SAPM_REG_STATUS, 16'h0001);
        pulse(5'h1e, 5'h02);
        pins(1'b0, 1'b0);
        rd("all latched", `SAPM_REG_STATUS, 16'h040f);
        wr(`SAPM_REG_CLEAR_FAULTS, 16'h0000);
        rd("ov persists", `SAPM_REG_STATUS, 16'h0002);
        pins(1'b1, 1'b1);
        cond <= 5'h00;
        wr(`SAPM_REG_CLEAR_FAULTS, 16'h0000);
        rd("all cleared", `SAPM_REG_STATUS, 16'h0000);
        wr(`SAPM_REG_PIN_TWO_SETUP, 16'h0fff);
        pulse(5'h01, 5'h00);
        pins(1'b0, 1'b0);
        wr(`SAPM_REG_PIN_TWO_SETUP, 16'h2fff);
        pins(1'b0, 1'b1);
        wr(`SAPM_REG_OPERATION, 16'h0000);
        check("op locked", {15'h0, output_on}, 16'h0001);
        wr(`SAPM_REG_DEVICE_CFG, 16'h0001);
        wr(`SAPM_REG_OPERATION, 16'h0000);
        check("op off", {15'h0, output_on}, 16'h0000);
        wr(`SAPM_REG_OPERATION, 16'h0001);
        rd("op cleared", `SAPM_REG_STATUS, 16'h0000);
        pins(1'b1, 1'b1);
        wr(`SAPM_REG_PIN_ONE_SETUP, 16'h4001);
        pins(1'b0, 1'b1);
        $display("Test status and pins done");
        for (i = 0; i < 16; i = i + 1) begin
            lfsr = next_rand(lfsr);
            ci = lfsr[11:0];
            cv = lfsr[23:12];
            sel = lfsr[24];
            pol = lfsr[13];
            cur_code <= lfsr[11:0];
            volt_code <= lfsr[23:12];
            latency <= {3'h0, lfsr[31:27]};
            wr(`SAPM_REG_MON_SETUP, {8'h0, lfsr[26:25], 1'b0, lfsr[26:25], lfsr[14], lfsr[24], 1'b0});
            wr(`SAPM_REG_DEVICE_CFG, {14'h0, lfsr[13], 1'b1});
            for (j = 0; j < 6; j = j + 1) begin
                lfsr = next_rand(lfsr);
                lim[j] = lfsr[12] ? (j < 4 ? cv : ci) : lfsr[11:0];
                wr(8'h30 + j[7:0], lim[j][15:0]);
            end
            wr(`SAPM_REG_CLEAR_FAULTS, 16'h0000);
            wr(`SAPM_REG_MON_START, 16'h0001);
            idle();
            if (ci > peak_i) peak_i = ci;
            if (cv > peak_v[sel]) peak_v[sel] = cv;
            want = 0;
            if (ci > lim[4]) want = want + 16;
            if (pol ? ci < lim[5] : ci > lim[5]) want = want + 32;
            if (cv < lim[1 + 2 * sel]) want = want + (64 << (2 * sel));
            if (cv > lim[2 * sel]) want = want + (128 << (2 * sel));
            rd("current", `SAPM_REG_READ_IOUT, ci[15:0]);
            rd("voltage", 8'h21 + sel[7:0], cv[15:0]);
            rd("max current", `SAPM_REG_MAX_IOUT, peak_i[15:0]);
            rd("max voltage", 8'h24 + sel[7:0], peak_v[sel][15:0]);
            rd("warnings", `SAPM_REG_STATUS, want[15:0]);
        end
        wr(`SAPM_REG_MAX_IOUT, 16'h0000);
        rd("max current cleared", `SAPM_REG_MAX_IOUT, 16'h0000);
        rd("max vin kept", `SAPM_REG_MAX_VIN, peak_v[0][15:0]);
        $display("Test single shot done");
        wr(`SAPM_REG_MON_SETUP, 16'h0001);
        wr(`SAPM_REG_MON_START, 16'h0001);
        j = 0;
        repeat (300) begin
            @(posedge clock);
            if (done) j = j + 1;
        end
        check("continuous runs", {15'h0, j > 2}, 16'h0001);
        wr(`SAPM_REG_MON_START, 16'h0000);
        idle();
        rd("stopped", `SAPM_REG_MON_START, 16'h0000);
        wr(`SAPM_REG_MON_SETUP, 16'h0000);
        wr(`SAPM_REG_PIN_ONE_SETUP, 16'h37ff);
        cur_code <= 12'h5a3;
        pin_in <= 1'b1;
        repeat (8) @(posedge clock);
        pin_in <= 1'b0;
        idle();
        rd("triggered sample", `SAPM_REG_READ_IOUT, 16'h05a3);
        pins(1'b1, 1'b1);
        $display("Test continuous and trigger done");
        finish_test();
    end
endmodule // test_status_alert_power_monitor_cmds
`default_nettype wire
